//--- smb_ctrl.sv
module smb_ctrl
    import smb_pkg::*;
(
    input  wire logic                        mclk_in,     // system clock
    input  wire logic                        reset_n_in,  // power-on reset
    input  wire logic                        glb_rst_in,  // global reset pulse
    // register port
    input  wire logic [smb_pkg::SMB_ADDR_W-1:0] addr_in,  // byte address
    input  wire logic [31:0]                 wdata_in,    // write data
    input  wire logic                        wr_in,       // write strobe
    input  wire logic                        rd_in,       // read strobe
    output logic      [31:0]                 rdata_out,   // read data
    // straps and debug select pins
    input  wire logic                        strap_mem_in,  // memory boot pin
    input  wire logic                        strap_ufs_in,  // flash-kind pin
    input  wire logic                        strap_test_in, // test pin
    input  wire logic                        debug_mux_select_hi_in, // sel hi
    input  wire logic                        debug_mux_select_lo_in, // sel lo
    // external test access pins
    input  wire logic                        jtck_in,     // test clock pin
    input  wire logic                        jtms_in,     // mode select pin
    input  wire logic                        jtdi_in,     // data in pin
    input  wire logic                        jtrst_n_in,  // test reset pin
    output logic                             jtdo_out,    // data out pin
    output logic                             jtdo_oe_out, // data out enable
    // cpu debug port
    output logic                             cpu_tck_out,   // cpu test clock
    output logic                             cpu_tms_out,   // cpu mode sel
    output logic                             cpu_tdi_out,   // cpu data in
    output logic                             cpu_trst_n_out,// cpu test reset
    input  wire logic                        cpu_tdo_in,    // cpu data out
    // register-selected debug target
    output logic                             tgt_tck_out,   // target clock
    output logic                             tgt_tms_out,   // target mode sel
    output logic                             tgt_tdi_out,   // target data in
    output logic                             tgt_trst_n_out,// target reset
    input  wire logic                        tgt_tdo_in,    // target data out
    output logic      [7:0]                  debug_target_select_out, // id
    // mode outputs
    output logic      [1:0]                  mode_out,      // current mode
    output logic      [1:0]                  boot_flow_out  // decoded flow
);
    // ==================================================================
    // declarations
    // ==================================================================
    smb_mode_type mode_reg;                         // current mode
    smb_mode_type mode_next;                        // next mode
    logic [2:0]   mode_sel_reg;                     // last written field
    logic [7:0]   dbg_target_reg;                   // debug target id
    logic [2:0]   strap_sync;                       // resynced straps
    logic [2:0]   strap_reg;                        // straps latched at boot
    logic         strap_done_reg;                   // straps captured
    logic [1:0]   dbg_sel_sync;                     // resynced selects
    logic [5:0]   jtag_sync;                        // resynced jtag lines
    logic [31:0]  rdata_next;                       // read mux

    // ==================================================================
    // mode field decode
    // ==================================================================
    function automatic smb_mode_type smb_decode_mode(input logic [2:0] f);
        smb_mode_type m;
        m = SMB_SLOW;
        if (f[2])
            m = SMB_NORMAL;
        else if (f[1])
            m = SMB_SLOW;
        else if (f[0])
            m = SMB_DOZE;
        else
            m = SMB_SLEEP;
        return m;
    endfunction : smb_decode_mode

    // ==================================================================
    // register decode
    // ==================================================================
    wire hit_mode   = (addr_in == SMB_MODE_CTRL_OFS);
    wire hit_strap  = (addr_in == SMB_BOOT_STRAP_OFS);
    wire hit_target = (addr_in == SMB_DBG_TARGET_OFS);
    wire hit_dbgst  = (addr_in == SMB_DBG_STATUS_OFS);
    wire wr_mode    = wr_in && hit_mode;
    wire wr_target  = wr_in && hit_target;

    // ==================================================================
    // synchronisers for pins
    // ==================================================================
    smb_sync #(.WIDTH(3)) u_strap_sync (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({strap_test_in, strap_ufs_in, strap_mem_in}),
        .sync_out   (strap_sync)
    );

    smb_sync #(.WIDTH(2)) u_sel_sync (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({debug_mux_select_hi_in, debug_mux_select_lo_in}),
        .sync_out   (dbg_sel_sync)
    );

    smb_sync #(.WIDTH(6)) u_jtag_sync (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({jtck_in, jtms_in, jtdi_in, jtrst_n_in,
                      cpu_tdo_in, tgt_tdo_in}),
        .sync_out   (jtag_sync)
    );

    // ==================================================================
    // mode state machine
    // ==================================================================
    // global reset wins over a write in the same cycle
    always_comb begin
        mode_next = mode_reg;
        if (glb_rst_in)
            mode_next = SMB_SLOW;
        else if (wr_mode)
            mode_next = smb_decode_mode(wdata_in[2:0]);
    end

    // state register, slow after power-on
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_reg     <= SMB_SLOW;
            mode_sel_reg <= SMB_MODE_SEL_RST;
        end else begin
            mode_reg <= mode_next;
            if (glb_rst_in)
                mode_sel_reg <= SMB_MODE_SEL_RST;
            else if (wr_mode)
                mode_sel_reg <= wdata_in[2:0];
        end
    end

    // ==================================================================
    // boot straps: caught once after reset release
    // ==================================================================
    // the sync chain needs two edges, so latch on the third
    logic [1:0] strap_wait_reg;                     // settle counter
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_wait_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            strap_reg      <= 3'h0;
        end else if (!strap_done_reg) begin
            if (strap_wait_reg == 2'h2) begin
                strap_reg      <= strap_sync;
                strap_done_reg <= 1'b1;
            end else begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
        end
    end

    // decoded boot flow for the boot code
    wire [1:0] flow_w = !strap_reg[SMB_STRAP_MEM_BIT] ? SMB_FLOW_USB :
                        strap_reg[SMB_STRAP_UFS_BIT]  ? SMB_FLOW_UFS :
                                                        SMB_FLOW_EMMC;

    // ==================================================================
    // debug target register
    // ==================================================================
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            dbg_target_reg <= SMB_DBG_TARGET_RST;
        else if (wr_target)
            dbg_target_reg <= wdata_in[7:0];
    end

    // ==================================================================
    // debug pin routing; pins pass two sync flops and an output flop in protocol order
    // ==================================================================
    wire route_cpu = (dbg_sel_sync == SMB_DBG_SEL_CPU);
    wire route_tgt = (dbg_sel_sync == SMB_DBG_SEL_REG);
    wire j_tck   = jtag_sync[5];
    wire j_tms   = jtag_sync[4];
    wire j_tdi   = jtag_sync[3];
    wire j_trstn = jtag_sync[2];
    wire c_tdo   = jtag_sync[1];
    wire t_tdo   = jtag_sync[0];

    // register the routed lines; idle lines park in test reset
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cpu_tck_out    <= 1'b0;
            cpu_tms_out    <= 1'b1;
            cpu_tdi_out    <= 1'b1;
            cpu_trst_n_out <= 1'b0;
            tgt_tck_out    <= 1'b0;
            tgt_tms_out    <= 1'b1;
            tgt_tdi_out    <= 1'b1;
            tgt_trst_n_out <= 1'b0;
            jtdo_out       <= 1'b0;
            jtdo_oe_out    <= 1'b0;
        end else begin
            cpu_tck_out    <= route_cpu & j_tck;
            cpu_tms_out    <= route_cpu ? j_tms : 1'b1;
            cpu_tdi_out    <= route_cpu ? j_tdi : 1'b1;
            cpu_trst_n_out <= route_cpu & j_trstn;
            tgt_tck_out    <= route_tgt & j_tck;
            tgt_tms_out    <= route_tgt ? j_tms : 1'b1;
            tgt_tdi_out    <= route_tgt ? j_tdi : 1'b1;
            tgt_trst_n_out <= route_tgt & j_trstn;
            jtdo_out       <= route_cpu ? c_tdo : (route_tgt & t_tdo);
            jtdo_oe_out    <= route_cpu | route_tgt;
        end
    end

    // ==================================================================
    // read mux; unmapped addresses read zero
    // ==================================================================
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_mode) begin
            rdata_next[2:0] = mode_sel_reg;
            rdata_next[5:4] = mode_reg;
        end else if (hit_strap) begin
            rdata_next[2:0] = strap_reg;
            rdata_next[5:4] = flow_w;
        end else if (hit_target) begin
            rdata_next[7:0] = dbg_target_reg;
        end else if (hit_dbgst) begin
            rdata_next[1:0] = dbg_sel_sync;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out               <= 32'h0000_0000;
            mode_out                <= SMB_SLOW;
            boot_flow_out           <= 2'h0;
            debug_target_select_out <= SMB_DBG_TARGET_RST;
        end else begin
            rdata_out               <= rd_in ? rdata_next : 32'h0000_0000;
            mode_out                <= mode_next;
            boot_flow_out           <= flow_w;
            debug_target_select_out <= dbg_target_reg;
        end
    end
endmodule : smb_ctrl

//--- smb_ctrl_assertions.sv
module smb_ctrl_assertions
    import smb_pkg::*;
(
    input wire logic [SMB_ADDR_W-1:0] addr_in,   // byte address
    input wire logic        mclk_in,             // clock
    input wire logic        reset_n_in,          // reset, low
    input wire logic        glb_rst_in,          // global reset
    input wire logic [31:0] wdata_in,            // write data
    input wire logic        wr_in,               // write strobe
    input wire logic        rd_in,               // read strobe
    input wire logic [31:0] rdata_out,           // read data
    input wire logic        debug_mux_select_hi_in, // select hi
    input wire logic        debug_mux_select_lo_in, // select lo
    input wire logic        jtck_in,             // test clock pin
    input wire logic        jtdi_in,             // data in pin
    input wire logic        cpu_tck_out,         // cpu test clock
    input wire logic        tgt_tdi_out,         // target data in
    input wire logic        jtdo_oe_out,         // data out enable
    input wire logic [1:0]  mode_out             // current mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);
    // ==============================================================
    // decode helpers
    // ==============================================================
    wire logic [1:0] dbg_sel = {debug_mux_select_hi_in,
                                debug_mux_select_lo_in}; // synced later
    wire logic       mode_wr = wr_in && !glb_rst_in
                               && addr_in == SMB_MODE_CTRL_OFS;
    // pins must stand four samples to pass two syncs and one flop
    sequence s_cpu_pins;
        (dbg_sel == 2'b01 && jtck_in) [*4];
    endsequence
    sequence s_tgt_pins;
        (dbg_sel == 2'b00 && !jtdi_in) [*4];
    endsequence
    // ==============================================================
    // mode machine
    // ==============================================================
    property p_sleep;
        mode_wr && wdata_in[2:0] == 3'h0 |=> mode_out == 2'h0;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep missed");
    property p_doze;
        mode_wr && wdata_in[2:0] == 3'h1 |=> mode_out == 2'h1;
    endproperty
    a_doze: assert property (p_doze) else $error("doze missed");
    property p_slow;
        mode_wr && wdata_in[2:1] == 2'h1 |=> mode_out == 2'h2;
    endproperty
    a_slow: assert property (p_slow) else $error("slow missed");
    property p_normal;
        mode_wr && wdata_in[2] |=> mode_out == 2'h3;
    endproperty
    a_normal: assert property (p_normal) else $error("normal bad");
    property p_por;
        $rose(reset_n_in) |-> mode_out == 2'h2;
    endproperty
    a_por: assert property (p_por) else $error("not slow at start");
    property p_glb;
        glb_rst_in |=> mode_out == 2'h2;
    endproperty
    a_glb: assert property (p_glb) else $error("global reset bad");
    property p_hold;
        !mode_wr && !glb_rst_in |=> $stable(mode_out);
    endproperty
    a_hold: assert property (p_hold) else $error("mode drifted");
    property p_readback;
        rd_in && addr_in == SMB_MODE_CTRL_OFS
            |=> rdata_out[5:4] == $past(mode_out);
    endproperty
    a_readback: assert property (p_readback) else $error("mode read");
    // ==============================================================
    // debug routing
    // ==============================================================
    property p_cpu;
        s_cpu_pins |-> cpu_tck_out;
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu route bad");
    property p_tgt;
        s_tgt_pins |-> !tgt_tdi_out && jtdo_oe_out;
    endproperty
    a_tgt: assert property (p_tgt) else $error("target route bad");
endmodule : smb_ctrl_assertions

bind smb_ctrl smb_ctrl_assertions u_chk (
    .addr_in, .mclk_in, .reset_n_in, .glb_rst_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .debug_mux_select_hi_in, .debug_mux_select_lo_in,
    .jtck_in, .jtdi_in, .cpu_tck_out, .tgt_tdi_out, .jtdo_oe_out,
    .mode_out
);

//--- smb_ctrl_tb.sv
module smb_ctrl_tb
    import smb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==============================================================
    // stimulus and observed signals
    // ==============================================================
    logic        mclk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        glb_rst_in = 1'b0;
    logic [11:0] addr_in = 12'h000;
    logic [31:0] wdata_in = 32'h0;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [2:0]  straps = 3'h0;    // test, flash kind, memory
    logic [1:0]  sel = 2'h0;       // debug mux select pins
    logic [5:0]  pins = 6'h0;      // tck tms tdi trst_n cpu_tdo tgt_tdo
    logic [31:0] rdata_out;
    wire  [3:0]  cpu_p;            // cpu test lines
    wire  [3:0]  tgt_p;            // target test lines
    logic        jtdo_out;
    logic        jtdo_oe_out;
    logic [7:0]  dbg_tgt;
    logic [1:0]  mode_out;
    logic [1:0]  boot_flow_out;
    logic [1:0]  exp_m = 2'h2;     // expected current mode
    logic [31:0] lfsr = 32'h0d74;  // random source
    logic [3:0]  park;             // idle level of test lines
    int          failures = 0;
    int          comparisons = 0;

    always #2 mclk_in = ~mclk_in;

    smb_ctrl uut (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .glb_rst_in(glb_rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .strap_mem_in(straps[0]),
        .strap_ufs_in(straps[1]), .strap_test_in(straps[2]),
        .debug_mux_select_hi_in(sel[1]), .debug_mux_select_lo_in(sel[0]),
        .jtck_in(pins[5]), .jtms_in(pins[4]), .jtdi_in(pins[3]),
        .jtrst_n_in(pins[2]), .jtdo_out(jtdo_out), .jtdo_oe_out(jtdo_oe_out),
        .cpu_tck_out(cpu_p[3]), .cpu_tms_out(cpu_p[2]),
        .cpu_tdi_out(cpu_p[1]), .cpu_trst_n_out(cpu_p[0]),
        .cpu_tdo_in(pins[1]), .tgt_tck_out(tgt_p[3]), .tgt_tms_out(tgt_p[2]),
        .tgt_tdi_out(tgt_p[1]), .tgt_trst_n_out(tgt_p[0]),
        .tgt_tdo_in(pins[0]), .debug_target_select_out(dbg_tgt),
        .mode_out(mode_out), .boot_flow_out(boot_flow_out)
    );
    // ==============================================================
    // expectation functions and bus tasks
    // ==============================================================
    function automatic logic [31:0] nxt(logic [31:0] x);
        return x[31] ? {x[30:0], 1'b0} ^ 32'h04c1_1db7 : {x[30:0], 1'b0};
    endfunction : nxt
    function automatic logic [1:0] emode(logic [2:0] f);
        return f[2] ? 2'h3 : (f[1] ? 2'h2 : {1'b0, f[0]});
    endfunction : emode
    function automatic logic [31:0] mreg(logic [2:0] f);
        return {26'h0, emode(f), 1'b0, f};
    endfunction : mreg
    function automatic logic [31:0] sreg(logic [2:0] s);
        return {26'h0, s[0] ? (s[1] ? 2'h2 : 2'h1) : 2'h0, 1'b0, s};
    endfunction : sreg
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic wr(logic [11:0] a, logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr
    // read, then compare data and current mode in the answer cycle
    task automatic rd_chk(logic [11:0] a, logic [31:0] e);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        check(rdata_out, e);
        check({30'h0, mode_out}, {30'h0, exp_m});
        @(posedge mclk_in);
    endtask : rd_chk
    // power-on reset with a given strap setting held throughout
    task automatic boot(logic [2:0] s);
        reset_n_in <= 1'b0;
        straps <= s;
        repeat (12) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (5) @(posedge mclk_in);
        exp_m = 2'h2;
        rd_chk(SMB_MODE_CTRL_OFS, mreg(3'h2));
        rd_chk(SMB_BOOT_STRAP_OFS, sreg(s));
        check({26'h0, boot_flow_out, 4'h0}, sreg(s) & 32'h0000_0030);
        rd_chk(SMB_DBG_TARGET_OFS, 32'h0);
    endtask : boot
    // ==============================================================
    // main sequence
    // ==============================================================
    initial begin
        park = 4'b0110;
        boot(3'h3);
        // every mode code, write and read back to back
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            wr(SMB_MODE_CTRL_OFS, {lfsr[31:3], i[2:0]});
            exp_m = emode(i[2:0]);
            rd_chk(SMB_MODE_CTRL_OFS, mreg(i[2:0]));
        end
        // random codes, mode held over idle gaps
        repeat (16) begin
            lfsr = nxt(lfsr);
            wr(SMB_MODE_CTRL_OFS, {29'h0, lfsr[2:0]});
            exp_m = emode(lfsr[2:0]);
            repeat (lfsr[7:4]) @(posedge mclk_in);
            rd_chk(SMB_MODE_CTRL_OFS, mreg(lfsr[2:0]));
        end
        // global reset alone, then beating a same-cycle write
        glb_rst_in <= 1'b1;
        @(posedge mclk_in);
        glb_rst_in <= 1'b0;
        exp_m = 2'h2;
        rd_chk(SMB_MODE_CTRL_OFS, mreg(3'h2));
        wr(SMB_MODE_CTRL_OFS, 32'h7);
        exp_m = 2'h3;
        rd_chk(SMB_MODE_CTRL_OFS, mreg(3'h7));
        glb_rst_in <= 1'b1;
        wr(SMB_MODE_CTRL_OFS, 32'h0);
        glb_rst_in <= 1'b0;
        exp_m = 2'h2;
        rd_chk(SMB_MODE_CTRL_OFS, mreg(3'h2));
        // read-only and unmapped places
        wr(SMB_BOOT_STRAP_OFS, 32'hffff_ffff);
        rd_chk(SMB_BOOT_STRAP_OFS, sreg(3'h3));
        rd_chk(12'h010, 32'h0);
        // debug target register
        repeat (4) begin
            lfsr = nxt(lfsr);
            wr(SMB_DBG_TARGET_OFS, lfsr);
            rd_chk(SMB_DBG_TARGET_OFS, {24'h0, lfsr[7:0]});
            check({24'h0, dbg_tgt}, {24'h0, lfsr[7:0]});
        end
        // every select code with random pin levels, three clocks late
        for (int s = 0; s < 4; s++) begin
            repeat (8) begin
                lfsr = nxt(lfsr);
                sel <= s[1:0];
                pins <= lfsr[5:0];
                repeat (3) @(posedge mclk_in);
                #1;
                check({22'h0, cpu_p, tgt_p, jtdo_oe_out,
                       jtdo_out},
                      {22'h0, s == 1 ? pins[5:2] : park,
                       s == 0 ? pins[5:2] : park, s < 2,
                       s < 2 && (s == 1 ? pins[1] : pins[0])});
                @(posedge mclk_in);
            end
            rd_chk(SMB_DBG_STATUS_OFS, {30'h0, s[1:0]});
        end
        // leave normal mode standing so the next power-on must undo it
        wr(SMB_MODE_CTRL_OFS, 32'h4);
        boot(3'h1);
        boot(3'h2);
        close_out();
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge mclk_in);
        failures++;
        close_out();
    end
endmodule : smb_ctrl_tb

//--- smb_pkg.sv
package smb_pkg;
    // ==================================================================
    // register map (byte addresses inside the block window)
    // ==================================================================
    localparam int          SMB_ADDR_W          = 12;
    localparam logic [11:0] SMB_MODE_CTRL_OFS   = 12'h000; // mode control
    localparam logic [11:0] SMB_BOOT_STRAP_OFS  = 12'h004; // strap status
    localparam logic [11:0] SMB_DBG_TARGET_OFS  = 12'h008; // debug target
    localparam logic [11:0] SMB_DBG_STATUS_OFS  = 12'h00c; // debug status

    // full system addresses of the mode control word, per master
    localparam logic [31:0] SMB_MODE_CTRL_MCU_ADDR  = 32'hfff0_a000;
    localparam logic [31:0] SMB_MODE_CTRL_CPU_ADDR  = 32'h4020_a000;

    // ==================================================================
    // field positions
    // ==================================================================
    localparam int SMB_MODE_SEL_LSB    = 0;   // mode-select field [2:0]
    localparam int SMB_MODE_STATE_LSB  = 4;   // current mode [5:4]
    localparam int SMB_STRAP_MEM_BIT   = 0;   // memory boot strap
    localparam int SMB_STRAP_UFS_BIT   = 1;   // flash-kind strap
    localparam int SMB_STRAP_TEST_BIT  = 2;   // test strap
    localparam int SMB_STRAP_FLOW_LSB  = 4;   // decoded boot flow [5:4]

    // ==================================================================
    // reset values
    // ==================================================================
    localparam logic [2:0] SMB_MODE_SEL_RST   = 3'h2;  // slow mode
    localparam logic [7:0] SMB_DBG_TARGET_RST = 8'h00;

    // debug mux select codes
    localparam logic [1:0] SMB_DBG_SEL_CPU = 2'h1;
    localparam logic [1:0] SMB_DBG_SEL_REG = 2'h0;

    // ==================================================================
    // enumerations
    // ==================================================================
    typedef enum logic [1:0] {
        SMB_SLEEP,
        SMB_DOZE,
        SMB_SLOW,
        SMB_NORMAL
    } smb_mode_type;

    typedef enum logic [1:0] {
        SMB_FLOW_USB,
        SMB_FLOW_EMMC,
        SMB_FLOW_UFS
    } smb_flow_type;
endpackage : smb_pkg

//--- smb_sync.sv
module smb_sync #(
    parameter int WIDTH = 1                         // bits to resync
) (
    input  wire logic             mclk_in,          // system clock
    input  wire logic             reset_n_in,       // async reset, low
    input  wire logic [WIDTH-1:0] async_in,         // raw pin levels
    output logic      [WIDTH-1:0] sync_out          // resynced levels
);
    // ==================================================================
    // two-flop synchroniser; first stage feeds only the second
    // ==================================================================
    logic [WIDTH-1:0] meta_reg;                     // first stage

    // capture pins through two stages
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : smb_sync
